//--- rtl/cantm_core.sv
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cantm_core (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic special_mode,
   input wire logic power_down,
   input wire logic osc_tick,
   input wire logic bus_receive_line,
   input wire logic proto_tx_bit,
   input wire logic proto_idle,
   input wire logic rx_err_evt,
   input wire logic tx_err_evt,
   output logic bus_transmit_line,
   output logic proto_rx_bit,
   output logic tq_tick,
   output logic sample_tick,
   output logic tx_point,
   output logic proto_abort,
   output logic tx_start_allowed
);
   logic ack_r;
   logic [31:0] dat_r;
   logic [7:0] ctl0_r;
   logic [7:0] ctl1_r;
   logic [7:0] btr0_r;
   logic [7:0] btr1_r;
   logic [7:0] idac_r;
   logic [7:0] rxerr_r;
   logic [7:0] txerr_r;
   logic [7:0] ifreg_r [cantm_pkg::N_IFREG];
   logic [7:0] code_r [cantm_pkg::N_FILT];
   logic [7:0] mask_r [cantm_pkg::N_FILT];
   logic en_written_r;
   logic init_ack_r;
   logic slp_ack_r;
   logic [cantm_pkg::BUS_SYNC_STAGES-1:0] req_sync_r;
   logic [1:0] can_cnt_r;
   logic can_init_r;
   logic [5:0] pcnt_r;
   cantm_pkg::cantm_bt_t bt_r;
   logic [4:0] qcnt_r;
   logic [2:0] ext_r;
   logic rx_prev_r;
   logic [2:0] smp_r;
   logic tx_r;
   logic rx_bit_r;
   logic txp_r;
   logic smp_tick_r;
   logic abort_r;
   logic init_prev_r;

   logic wr;
   logic rd;
   logic init_mode;
   logic locked;
   logic enable;
   logic listen;
   logic can_tick;
   logic tq;
   logic edge_seen;
   logic majority;
   logic [4:0] seg1_end;
   logic [4:0] seg2_end;
   logic [4:0] sjw_len;
   logic [4:0] err_ext;
   logic [4:0] remain2;
   logic hit_code;
   logic hit_mask;
   logic hit_if;
   logic [2:0] idx;
   cantm_pkg::cantm_btr_t btr;

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
   assign init_mode = ctl0_r[cantm_pkg::B_INIT_REQUEST] & init_ack_r;
   // special lifts lock
   // Emulation has no separate input, so it sees normal locking.
   assign locked = ~init_mode & ~special_mode;
   assign enable = ctl1_r[cantm_pkg::B_ENABLE];
   assign listen = ctl1_r[cantm_pkg::B_LISTEN];
   assign btr = {btr0_r, btr1_r};
   assign idx = wb_adr_i[4:2];
   assign hit_code = wb_adr_i[7:5] == cantm_pkg::OFS_CODE[7:5];
   assign hit_mask = wb_adr_i[7:5] == cantm_pkg::OFS_MASK[7:5];
   assign hit_if = (wb_adr_i[7:5] == cantm_pkg::OFS_IFREG[7:5])
      && (idx < 3'(cantm_pkg::N_IFREG));

   // Wishbone ack: one cycle per request, dropped the cycle after
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Read mux; unmapped offsets read as zero but still acknowledge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dat_r <= 32'h00000000;
      end else if (rd) begin
         dat_r <= 32'h00000000;
         if (hit_code) begin
            dat_r[7:0] <= code_r[idx];
         end else if (hit_mask) begin
            dat_r[7:0] <= mask_r[idx];
         end else if (hit_if) begin
            dat_r[7:0] <= ifreg_r[idx];
         end else begin
            unique case (wb_adr_i)
               cantm_pkg::OFS_CTL0: dat_r[7:0] <= ctl0_r;
               cantm_pkg::OFS_CTL1: dat_r[7:0] <= {ctl1_r[7:2],
                  slp_ack_r, init_ack_r};
               cantm_pkg::OFS_BTR0: dat_r[7:0] <= btr0_r;
               cantm_pkg::OFS_BTR1: dat_r[7:0] <= btr1_r;
               cantm_pkg::OFS_IDAC: dat_r[7:0] <= idac_r;
               cantm_pkg::OFS_RXERR: dat_r[7:0] <= rxerr_r;
               cantm_pkg::OFS_TXERR: dat_r[7:0] <= txerr_r;
               default: dat_r <= 32'h00000000;
            endcase
         end
      end
   end

   // Control zero: init and sleep requests plus general bits
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0_r <= cantm_pkg::RST_CTL0;
      end else if (wr && wb_adr_i == cantm_pkg::OFS_CTL0) begin
         ctl0_r[7:2] <= init_mode ? 6'h00 : wb_dat_i[7:2];
         ctl0_r[cantm_pkg::B_SLEEP_REQUEST] <= init_mode ? 1'b0
            : wb_dat_i[cantm_pkg::B_SLEEP_REQUEST];
         if (wb_dat_i[cantm_pkg::B_INIT_REQUEST] || init_mode) begin
            ctl0_r[cantm_pkg::B_INIT_REQUEST] <= wb_dat_i[cantm_pkg::B_INIT_REQUEST];
         end
      end else if (wr && wb_adr_i == cantm_pkg::OFS_CTL1 && !locked
            && !enable && wb_dat_i[cantm_pkg::B_ENABLE]) begin
         ctl0_r[cantm_pkg::B_INIT_REQUEST] <= 1'b1;
      end else if (init_mode) begin
         ctl0_r <= cantm_pkg::RST_CTL0;
      end
   end

   // Control one; enable is write-once unless special mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl1_r <= cantm_pkg::RST_CTL1;
         en_written_r <= 1'b0;
      end else if (wr && wb_adr_i == cantm_pkg::OFS_CTL1) begin
         if (!locked) begin
            ctl1_r[7:2] <= wb_dat_i[7:2];
            if (en_written_r && !special_mode) begin
               ctl1_r[cantm_pkg::B_ENABLE] <= enable;
            end
         end
         if (!locked) begin
            en_written_r <= 1'b1;
         end
      end
   end

   // Timing and filter configuration, writable only while the lock is open
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         btr0_r <= cantm_pkg::RST_BYTE;
         btr1_r <= cantm_pkg::RST_BYTE;
         idac_r <= cantm_pkg::RST_BYTE;
      end else if (wr && !locked) begin
         unique case (wb_adr_i)
            cantm_pkg::OFS_BTR0: btr0_r <= wb_dat_i[7:0];
            cantm_pkg::OFS_BTR1: btr1_r <= wb_dat_i[7:0];
            cantm_pkg::OFS_IDAC: idac_r <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Acceptance code and mask per entry; interface flag registers only for entries below N_IFREG
   for (genvar i = 0; i < cantm_pkg::N_FILT; i++) begin : g_filt
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            code_r[i] <= cantm_pkg::RST_BYTE;
            mask_r[i] <= cantm_pkg::RST_BYTE;
         end else if (wr && !locked && idx == 3'(i)) begin
            if (hit_code) begin
               code_r[i] <= wb_dat_i[7:0];
            end
            if (hit_mask) begin
               mask_r[i] <= wb_dat_i[7:0];
            end
         end
      end
      if (i < cantm_pkg::N_IFREG) begin : g_if
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               ifreg_r[i] <= cantm_pkg::RST_BYTE;
            end else if (init_mode) begin
               ifreg_r[i] <= cantm_pkg::RST_BYTE;
            end else if (wr && hit_if && idx == 3'(i)) begin
               ifreg_r[i] <= wb_dat_i[7:0];
            end
         end
      end
   end

   // Error counters move only on protocol events, saturating, and clear in init
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxerr_r <= cantm_pkg::RST_BYTE;
         txerr_r <= cantm_pkg::RST_BYTE;
      end else if (init_mode) begin
         rxerr_r <= cantm_pkg::RST_BYTE;
         txerr_r <= cantm_pkg::RST_BYTE;
      end else begin
         if (rx_err_evt && rxerr_r != 8'hff) begin
            rxerr_r <= rxerr_r + 8'h01;
         end
         if (tx_err_evt && txerr_r != 8'hff) begin
            txerr_r <= txerr_r + 8'h01;
         end
      end
   end

   // clock source select
   // CAN domain modelled as ticks of core_clk; oscillator arrives as a tick.
   assign can_tick = enable & (ctl1_r[cantm_pkg::B_CLOCK_SOURCE_SELECT] | osc_tick);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_sync_r <= '0;
      end else begin
         req_sync_r <= {req_sync_r[cantm_pkg::BUS_SYNC_STAGES-2:0],
            ctl0_r[cantm_pkg::B_INIT_REQUEST]};
      end
   end

   // CAN-side three ticks
   // The CAN part follows the synced request after three CAN ticks,
   // even mid-frame: entering init has to cut a transfer at once.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         can_cnt_r <= 2'h0;
         can_init_r <= 1'b1;
      end else if (req_sync_r[cantm_pkg::BUS_SYNC_STAGES-1] == can_init_r)
         begin
         can_cnt_r <= 2'h0;
      end else if (can_tick) begin
         if (can_cnt_r == cantm_pkg::CAN_SYNC_TICKS - 2'h1) begin
            can_init_r <= ~can_init_r;
            can_cnt_r <= 2'h0;
         end else begin
            can_cnt_r <= can_cnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_ack_r <= 1'b0;
      end else begin
         init_ack_r <= can_init_r & ctl0_r[cantm_pkg::B_INIT_REQUEST];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         slp_ack_r <= 1'b0;
      end else begin
         slp_ack_r <= ctl0_r[cantm_pkg::B_SLEEP_REQUEST] & (slp_ack_r | proto_idle);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt_r <= 6'h00;
      end else if (can_init_r || !can_tick) begin
         pcnt_r <= can_init_r ? 6'h00 : pcnt_r;
      end else begin
         pcnt_r <= (pcnt_r == btr.presc) ? 6'h00 : pcnt_r + 6'h01;
      end
   end
   assign tq = can_tick & ~can_init_r & (pcnt_r == btr.presc);
   assign tq_tick = tq;

   assign sjw_len = {3'h0, btr.resync_jump_width} + 5'h01;
   assign seg1_end = {1'b0, btr.first_time_segment} + {2'h0, ext_r};
   assign seg2_end = {2'h0, btr.second_time_segment};
   assign remain2 = seg2_end - qcnt_r;
   assign err_ext = (qcnt_r + 5'h01 < sjw_len) ? qcnt_r + 5'h01 : sjw_len;
   assign edge_seen = rx_prev_r & ~bus_receive_line;
   assign majority = (smp_r[0] & smp_r[1]) | (smp_r[0] & bus_receive_line)
      | (smp_r[1] & bus_receive_line);

   // Bit timing sequencer; enters off state whenever init is held
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bt_r <= cantm_pkg::BT_OFF;
         qcnt_r <= 5'h00;
         ext_r <= 3'h0;
      end else if (can_init_r) begin
         bt_r <= cantm_pkg::BT_OFF;
         qcnt_r <= 5'h00;
         ext_r <= 3'h0;
      end else if (tq) begin
         unique case (bt_r)
            // Hard sync on the first recessive-to-dominant edge
            cantm_pkg::BT_OFF: if (edge_seen) begin
               bt_r <= cantm_pkg::BT_SEG1;
               qcnt_r <= 5'h00;
            end
            cantm_pkg::BT_SYNC: begin
               bt_r <= cantm_pkg::BT_SEG1;
               qcnt_r <= 5'h00;
               ext_r <= 3'h0;
            end
            cantm_pkg::BT_SEG1: begin
               // Late edge lengthens segment one by up to jump width
               if (edge_seen && ext_r == 3'h0) begin
                  ext_r <= err_ext[2:0];
               end
               if (qcnt_r == seg1_end) begin
                  bt_r <= cantm_pkg::BT_SEG2;
                  qcnt_r <= 5'h00;
               end else begin
                  qcnt_r <= qcnt_r + 5'h01;
               end
            end
            cantm_pkg::BT_SEG2: begin
               // Early edge cuts segment two when within jump width
               if (edge_seen && remain2 <= sjw_len) begin
                  bt_r <= cantm_pkg::BT_SEG1;
                  qcnt_r <= 5'h00;
                  ext_r <= 3'h0;
               end else if (qcnt_r == seg2_end) begin
                  bt_r <= cantm_pkg::BT_SYNC;
                  qcnt_r <= 5'h00;
               end else begin
                  qcnt_r <= qcnt_r + 5'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_prev_r <= 1'b1;
         smp_r <= 3'h7;
         rx_bit_r <= 1'b1;
         txp_r <= 1'b0;
         smp_tick_r <= 1'b0;
         tx_r <= 1'b1;
      end else begin
         txp_r <= tq && bt_r == cantm_pkg::BT_SEG2
            && qcnt_r == seg2_end;
         smp_tick_r <= tq && bt_r == cantm_pkg::BT_SEG1
            && qcnt_r == seg1_end;
         if (tq) begin
            rx_prev_r <= bus_receive_line;
            smp_r <= {smp_r[1:0], bus_receive_line};
         end
         if (tq && bt_r == cantm_pkg::BT_SEG1 && qcnt_r == seg1_end) begin
            rx_bit_r <= btr.triple ? majority : bus_receive_line;
         end
         // recessive in init or power down
         if (can_init_r || power_down || listen) begin
            tx_r <= 1'b1;
         end else if (tq && bt_r == cantm_pkg::BT_SEG2
               && qcnt_r == seg2_end) begin
            tx_r <= proto_tx_bit;
         end
      end
   end
   // Power down also acts combinationally, so the pin goes at once
   assign bus_transmit_line = tx_r | power_down;
   assign tx_point = txp_r;
   assign sample_tick = smp_tick_r;
   assign proto_rx_bit = listen ? (rx_bit_r & proto_tx_bit) : rx_bit_r;
   assign tx_start_allowed = ~listen & ~can_init_r & enable & ~slp_ack_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_prev_r <= 1'b1;
         abort_r <= 1'b0;
      end else begin
         init_prev_r <= can_init_r;
         abort_r <= can_init_r & ~init_prev_r;
      end
   end
   assign proto_abort = abort_r;
endmodule // cantm_core
`default_nettype wire

//--- rtl/cantm_pkg.sv
// Overview of operation
// - Error counters ignore every bus write; only protocol events move them (init also clears them here).
// - Control one, timing, filter control, code and mask need init lock open.
// - Transmit line goes recessive at once in power down or init.
// - Module enable bit accepts only its first write in normal modes.
// - Core CAN clock follows oscillator tick or bus clock per source select.
// - Prescaler divides core CAN clock into time quanta for all timing.
// - Synchronisation segment is exactly one quantum; edges expected there.
// - First time segment programmable from 4 to 16 quanta.
// - Second time segment programmable from 2 to 8 quanta.
// - Jump width programmable from 1 to 4 quanta via timing registers.
// - Transmit at transmit point, sample at sample point; triple takes majority of three.
// - Special modes lift the write restrictions for test.
// - Emulation modes keep the normal write restrictions.
// - Listen-only receives, sends only recessive, never starts transmission.
// - Listen-only dominant bits loop back internally only.
// - Enabling the module puts it in initialization mode.
// - Entering init aborts transfers and drops bus synchronisation.
// - Init stops engine, keeps registers, resets control zero and flag regs; error counters are cleared too.
// - Init request crosses by handshake: two bus plus three CAN clocks.
// - Acknowledge sets only when all parts are in init; software waits.
// - Clearing init request ignored until request and acknowledge both set.
// - Sleep is active when sleep request and acknowledge are both set.
package cantm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_CTL1 = 8'h04;
   localparam logic [7:0] OFS_BTR0 = 8'h08;
   localparam logic [7:0] OFS_BTR1 = 8'h0c;
   localparam logic [7:0] OFS_IDAC = 8'h10;
   localparam logic [7:0] OFS_RXERR = 8'h14;
   localparam logic [7:0] OFS_TXERR = 8'h18;
   localparam logic [7:0] OFS_IFREG = 8'h20;
   localparam logic [7:0] OFS_CODE = 8'h40;
   localparam logic [7:0] OFS_MASK = 8'h60;
   localparam int N_IFREG = 7;
   localparam int N_FILT = 8;
   // Field positions
   localparam int B_INIT_REQUEST = 0;
   localparam int B_SLEEP_REQUEST = 1;
   localparam int B_INIT_ACKNOWLEDGE = 0;
   localparam int B_SLEEP_ACKNOWLEDGE = 1;
   localparam int B_LISTEN = 4;
   localparam int B_CLOCK_SOURCE_SELECT = 6;
   localparam int B_ENABLE = 7;
   // Reset values
   localparam logic [7:0] RST_CTL0 = 8'h01;
   localparam logic [7:0] RST_CTL1 = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Handshake timing counts
   localparam int BUS_SYNC_STAGES = 2;
   localparam logic [1:0] CAN_SYNC_TICKS = 2'h3;
   // Bit timing configuration carried as one bundle
   typedef struct packed {
      logic [1:0] resync_jump_width;
      logic [5:0] presc;
      logic triple;
      logic [2:0] second_time_segment;
      logic [3:0] first_time_segment;
   } cantm_btr_t;
   typedef enum logic [1:0] {
      BT_OFF,
      BT_SYNC,
      BT_SEG1,
      BT_SEG2
   } cantm_bt_t;
endpackage

//--- verification/cantm_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cantm_bus_model (
   input wire logic tx_line,
   input wire logic force_dom,
   output logic rx_line
);
   // Wired-AND bus with pull-up: another node sending dominant always wins
   assign rx_line = tx_line & ~force_dom;
endmodule // cantm_bus_model
`default_nettype wire

//--- verification/cantm_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cantm_core_assertions (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic power_down,
   input wire logic bus_transmit_line,
   input wire logic tq_tick,
   input wire logic sample_tick,
   input wire logic tx_point,
   input wire logic proto_abort
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_ack_next_cycle:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");
   a_ack_one_pulse:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_dat_upper_zero:
   assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_pd_recessive:
   assert property (power_down |-> bus_transmit_line)
      else $error("transmit line dominant in power down");
   a_abort_recessive:
   assert property (proto_abort |-> bus_transmit_line)
      else $error("transmit line dominant at init entry");
   a_sample_on_tq:
   assert property (sample_tick |-> $past(tq_tick))
      else $error("sample tick without quantum");
   a_txpt_on_tq:
   assert property (tx_point |-> $past(tq_tick))
      else $error("transmit point without quantum");
   a_points_apart:
   assert property (sample_tick |=> !tx_point)
      else $error("transmit point too close to sample point");
endmodule // cantm_core_assertions
bind cantm_core cantm_core_assertions u_chk (.core_clk(core_clk),
   .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .power_down(power_down),
   .bus_transmit_line(bus_transmit_line), .tq_tick(tq_tick),
   .sample_tick(sample_tick), .tx_point(tx_point),
   .proto_abort(proto_abort));
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, reset_n, cyc, stb, we, ack, pd, spec, ptx, force_dom;
   logic rxe, txe, rxl, txl, prx, tq, smp, txp, abrt, txok, abort_seen;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   logic [1:0] osc_cnt;
   int fail_count, cmp_count;
   cantm_core u_dut (.core_clk(core_clk), .reset_n(reset_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .special_mode(spec), .power_down(pd), .osc_tick(osc_cnt == 2'h0),
      .bus_receive_line(rxl), .proto_tx_bit(ptx), .proto_idle(1'b1),
      .rx_err_evt(rxe), .tx_err_evt(txe), .bus_transmit_line(txl),
      .proto_rx_bit(prx), .tq_tick(tq), .sample_tick(smp), .tx_point(txp),
      .proto_abort(abrt), .tx_start_allowed(txok));
   cantm_bus_model u_bus (.tx_line(txl), .force_dom(force_dom),
      .rx_line(rxl));
   // Slow oscillator: one tick every third cycle
   always @(posedge core_clk)
      osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
   // Latch the abort pulse so it cannot be missed between polls
   always @(posedge core_clk) if (abrt === 1'b1) abort_seen <= 1'b1;
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic tally_and_finish;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic hang_out;
      fail_count++;
      tally_and_finish();
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) hang_out();
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, m, e);
      logic [7:0] q;
      xfer(1'b0, a, 8'h00, q);
      check(nm, {24'h000000, q & m}, {24'h000000, e});
   endtask
   // Poll the acknowledge flag; software has no other handshake
   task automatic wait_ack(input logic v);
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         xfer(1'b0, cantm_pkg::OFS_CTL1, 8'h00, q);
         n++;
      end while (q[cantm_pkg::B_INIT_ACKNOWLEDGE] !== v && n < 100);
      if (n >= 100) hang_out();
   endtask
   task automatic count_to(input logic t, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((t ? txp : smp) !== 1'b1 && n < 200);
      if (n >= 200) hang_out();
   endtask
   // First partial bit is skipped, then one whole bit is timed
   task automatic measure(input int seg2, len);
      int a, b, c;
      // Idle recessive bus, then another node starts a frame: its falling
      // edge hard-syncs us, and holding it dominant stops any resync
      repeat (20) @(posedge core_clk);
      force_dom <= 1'b1;
      count_to(1'b0, a);
      count_to(1'b1, b);
      count_to(1'b0, c);
      check("seg2 span", b, seg2);
      check("bit span", b + c, len);
      force_dom <= 1'b0;
   endtask
   initial begin
      {cyc, stb, we, pd, spec, force_dom, rxe, txe, abort_seen} = '0;
      adr = 8'h00;
      wdat = 32'h0;
      ptx = 1'b1;
      osc_cnt = 2'h0;
      reset_n = 1'b0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd_chk("ctl0 reset", cantm_pkg::OFS_CTL0, 8'hff,
         cantm_pkg::RST_CTL0);
      wait_ack(1'b1);
      wr(cantm_pkg::OFS_CTL1, 8'hc0);
      rd_chk("ctl1 enabled", cantm_pkg::OFS_CTL1, 8'hd3, 8'hc1);
      wr(cantm_pkg::OFS_BTR0, 8'hc0);
      wr(cantm_pkg::OFS_BTR1, 8'h13);
      rd_chk("btr0", cantm_pkg::OFS_BTR0, 8'hff, 8'hc0);
      rd_chk("btr1", cantm_pkg::OFS_BTR1, 8'hff, 8'h13);
      for (int i = 0; i < cantm_pkg::N_FILT; i++) begin
         wr(cantm_pkg::OFS_CODE + 8'(4 * i), 8'ha0 + 8'(i));
         wr(cantm_pkg::OFS_MASK + 8'(4 * i), 8'h50 + 8'(i));
         rd_chk("code", cantm_pkg::OFS_CODE + 8'(4 * i), 8'hff,
            8'ha0 + 8'(i));
         rd_chk("mask", cantm_pkg::OFS_MASK + 8'(4 * i), 8'hff,
            8'h50 + 8'(i));
      end
      wr(cantm_pkg::OFS_RXERR, 8'hff);
      wr(cantm_pkg::OFS_TXERR, 8'hff);
      rd_chk("rx err", cantm_pkg::OFS_RXERR, 8'hff, 8'h00);
      rd_chk("tx err", cantm_pkg::OFS_TXERR, 8'hff, 8'h00);
      wr(cantm_pkg::OFS_CTL0, 8'h00);
      wait_ack(1'b0);
      measure(2, 7);
      rxe <= 1'b1;
      txe <= 1'b1;
      @(posedge core_clk);
      rxe <= 1'b0;
      txe <= 1'b0;
      wr(cantm_pkg::OFS_RXERR, 8'h00);
      rd_chk("rx err count", cantm_pkg::OFS_RXERR, 8'hff, 8'h01);
      rd_chk("tx err count", cantm_pkg::OFS_TXERR, 8'hff, 8'h01);
      wr(cantm_pkg::OFS_BTR1, 8'h7f);
      wr(cantm_pkg::OFS_CODE, 8'hff);
      rd_chk("btr1 locked", cantm_pkg::OFS_BTR1, 8'hff, 8'h13);
      rd_chk("code locked", cantm_pkg::OFS_CODE, 8'hff, 8'ha0);
      spec <= 1'b1;
      wr(cantm_pkg::OFS_BTR1, 8'h25);
      rd_chk("btr1 special", cantm_pkg::OFS_BTR1, 8'hff, 8'h25);
      wr(cantm_pkg::OFS_BTR1, 8'h13);
      spec <= 1'b0;
      wr(cantm_pkg::OFS_IFREG, 8'hff);
      ptx <= 1'b0;
      repeat (20) @(posedge core_clk);
      check("tx dominant", txl, 1'b0);
      abort_seen <= 1'b0;
      wr(cantm_pkg::OFS_CTL0, 8'h01);
      rd_chk("ack delayed", cantm_pkg::OFS_CTL1, 8'h01, 8'h00);
      wait_ack(1'b1);
      check("tx init", txl, 1'b1);
      check("abort", abort_seen, 1'b1);
      rd_chk("flags reset", cantm_pkg::OFS_IFREG, 8'hff,
         cantm_pkg::RST_BYTE);
      wr(cantm_pkg::OFS_CTL1, 8'h40);
      rd_chk("enable once", cantm_pkg::OFS_CTL1, 8'hc0, 8'hc0);
      wr(cantm_pkg::OFS_BTR0, 8'hc1);
      wr(cantm_pkg::OFS_CTL0, 8'h00);
      wait_ack(1'b0);
      measure(4, 14);
      pd <= 1'b1;
      #1 check("tx power down", txl, 1'b1);
      @(posedge core_clk);
      pd <= 1'b0;
      // Software parks the node in sleep before asking for init
      wr(cantm_pkg::OFS_CTL0, 8'h02);
      rd_chk("sleep ack", cantm_pkg::OFS_CTL1, 8'h02, 8'h02);
      wr(cantm_pkg::OFS_CTL0, 8'h03);
      wait_ack(1'b1);
      wr(cantm_pkg::OFS_BTR0, 8'hc0);
      wr(cantm_pkg::OFS_CTL1, 8'h00);
      wr(cantm_pkg::OFS_CTL0, 8'h00);
      wait_ack(1'b0);
      measure(6, 21);
      wr(cantm_pkg::OFS_CTL0, 8'h01);
      wr(cantm_pkg::OFS_CTL0, 8'h00);
      rd_chk("early clear", cantm_pkg::OFS_CTL0, 8'h01, 8'h01);
      wait_ack(1'b1);
      wr(cantm_pkg::OFS_CTL1, 8'h10);
      // Listen test also runs with three samples per bit
      wr(cantm_pkg::OFS_BTR1, 8'h93);
      wr(cantm_pkg::OFS_CTL0, 8'h00);
      wait_ack(1'b0);
      // Engine asks for dominant, yet the wire must stay recessive
      repeat (30) begin
         @(posedge core_clk);
         check("listen tx", txl, 1'b1);
      end
      check("listen start", txok, 1'b0);
      check("loopback", prx, 1'b0);
      ptx <= 1'b1;
      force_dom <= 1'b1;
      repeat (50) @(posedge core_clk);
      check("listen rx dom", prx, 1'b0);
      force_dom <= 1'b0;
      repeat (50) @(posedge core_clk);
      check("listen rx rec", prx, 1'b1);
      // Recessive bus, dominant from the engine: only the loop shows it
      ptx <= 1'b0;
      @(posedge core_clk);
      check("loopback dom", prx, 1'b0);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
